// *** rtl/core_interrupt_end.sv ***
// core_interrupt_end: the core's interrupt flags, masks and taking logic, plus a link master.
// assumes software on axi4-lite; one write and one read outstanding at most.
`timescale 1ns/1ps
module core_interrupt_end
    import evt_irq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        nmi_n,
    input  wire logic [2:0]  other_lines_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    evt_irq_if.core          link
);

    core_state_t q;
    core_state_t d;
    logic [5:0]  lines_n;
    logic [5:0]  fall;
    logic [5:0]  sw_clr;
    logic [5:0]  take_clr;
    logic [5:0]  eligible;
    logic        do_write;

    // bit 0 = line one (highest maskable priority)
    assign lines_n = {other_lines_n[2], other_lines_n[1], link.core_line_four_n,
                      link.core_line_three_n, link.core_line_two_n, other_lines_n[0]};

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready  = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        d        = q;
        d.sel    = 1'b0;
        sw_clr   = '0;
        take_clr = '0;
        fall     = q.lines_prev & ~lines_n;
        d.lines_prev = lines_n;
        d.nmi_prev   = nmi_n;
        if (s_axi_awvalid && s_axi_awready)
        begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            d.w_got     = 1'b1;
            d.axi_wdata = s_axi_wdata;
        end
        // a write commits once both halves are held; byte strobes are not used
        do_write = q.aw_got && q.w_got;
        if (do_write)
        begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            case (q.awaddr)
                OFS_CORE_MASK: d.core_mask   = q.axi_wdata[5:0];
                OFS_GLOBAL:    d.global_mask = q.axi_wdata[0];
                OFS_CORE_FLAG: sw_clr        = q.axi_wdata[5:0];
                OFS_CMD_WDATA: d.cmd_wdata   = q.axi_wdata[15:0];
                OFS_CMD:
                begin
                    // a command while busy is dropped
                    if (!q.busy)
                    begin
                        d.busy  = 1'b1;
                        d.sel   = 1'b1;
                        d.wr    = q.axi_wdata[CMD_WR_POS];
                        d.addr  = q.axi_wdata[3:0];
                        d.wdata = q.cmd_wdata;
                    end
                end
                default: ;
            endcase
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (q.busy && link.bus_ack)
        begin
            d.busy      = 1'b0;
            d.dev_rdata = link.bus_rdata;
        end
        // taking: nmi first, then lowest line number
        eligible = q.core_flag & q.core_mask;
        if (q.nmi_flag)
        begin
            d.nmi_flag = 1'b0;
            d.taken_id = TAKEN_NMI;
        end
        else if (!q.global_mask && |eligible)
        begin
            take_clr = eligible & (~eligible + 6'h01);
            d.global_mask = 1'b1;
            for (int i = 5; i >= 0; i--)
            begin
                if (eligible[i])
                begin
                    d.taken_id = 3'(i + 1);
                end
            end
        end
        if (q.nmi_prev && !nmi_n)
        begin
            d.nmi_flag = 1'b1;
        end
        d.core_flag = (q.core_flag & ~sw_clr & ~take_clr) | fall;
        if (s_axi_arvalid && s_axi_arready)
        begin
            d.rvalid = 1'b1;
            case (s_axi_araddr)
                OFS_CORE_MASK:  d.rdata = {26'h0, q.core_mask};
                OFS_GLOBAL:     d.rdata = {31'h0, q.global_mask};
                OFS_CORE_FLAG:  d.rdata = {23'h0, q.nmi_flag, 2'h0, q.core_flag};
                OFS_TAKEN:      d.rdata = {29'h0, q.taken_id};
                OFS_CMD:        d.rdata = {23'h0, q.wr, 4'h0, q.addr};
                OFS_CMD_WDATA:  d.rdata = {16'h0, q.cmd_wdata};
                OFS_DEV_STATUS: d.rdata = {q.dev_rdata, 15'h0, q.busy};
                default:        d.rdata = 32'h0000_0000;
            endcase
        end
        else if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= CORE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign s_axi_bresp    = 2'h0;
    assign s_axi_bvalid   = q.bvalid;
    assign s_axi_rresp    = 2'h0;
    assign s_axi_rvalid   = q.rvalid;
    assign s_axi_rdata    = q.rdata;
    assign link.bus_sel   = q.sel;
    assign link.bus_wr    = q.wr;
    assign link.bus_addr  = q.addr;
    assign link.bus_wdata = q.wdata;

endmodule // core_interrupt_end

// *** rtl/evt_irq_pkg.sv ***
// evt_irq_pkg: constants and state types shared by both ends of the event interrupt link.
// assumes one 25 MHz clock (aclk) and synchronous active-low reset on both ends.
package evt_irq_pkg;
    localparam int NUM_GROUPS = 3;
    localparam int REG_W      = 16;
    localparam int VEC_W      = 8;
    localparam int ADDR_W     = 4;

    // device register indices on the link bus
    localparam logic [3:0] IDX_FLAG_A = 4'h0;
    localparam logic [3:0] IDX_MASK_A = 4'h3;
    localparam logic [3:0] IDX_VEC_A  = 4'h6;

    // implemented flag bits and vector bases, index 0 = group a
    localparam logic [2:0][15:0] GRP_USED     = {16'h000f, 16'h00ff, 16'h07ff};
    localparam logic [2:0][7:0]  GRP_VEC_BASE = {8'h33, 8'h2b, 8'h20};
    localparam logic [7:0]       VEC_NONE     = 8'h00;

    // core end axi4-lite register offsets
    localparam logic [7:0] OFS_CORE_MASK  = 8'h00;
    localparam logic [7:0] OFS_GLOBAL     = 8'h04;
    localparam logic [7:0] OFS_CORE_FLAG  = 8'h08;
    localparam logic [7:0] OFS_TAKEN      = 8'h0c;
    localparam logic [7:0] OFS_CMD        = 8'h10;
    localparam logic [7:0] OFS_CMD_WDATA  = 8'h14;
    localparam logic [7:0] OFS_DEV_STATUS = 8'h18;
    localparam int         NMI_FLAG_POS   = 8;
    localparam int         CMD_WR_POS     = 8;
    localparam logic [2:0] TAKEN_NONE     = 3'h0;
    localparam logic [2:0] TAKEN_NMI      = 3'h7;

    typedef struct packed {
        logic [2:0][15:0] flag;
        logic [2:0][15:0] mask;
        logic [2:0]       line_n;
        logic             ack;
        logic [15:0]      rdata;
    } dev_state_t;

    localparam dev_state_t DEV_RST = '{flag: '0, mask: '0, line_n: 3'b111,
                                       ack: 1'b0, rdata: '0};

    typedef struct packed {
        logic [5:0]  core_flag;
        logic [5:0]  core_mask;
        logic        global_mask;
        logic        nmi_flag;
        logic [5:0]  lines_prev;
        logic        nmi_prev;
        logic [2:0]  taken_id;
        logic        busy;
        logic        sel;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [15:0] dev_rdata;
        logic [15:0] cmd_wdata;
        logic        aw_got;
        logic [7:0]  awaddr;
        logic        w_got;
        logic [31:0] axi_wdata;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
    } core_state_t;

    localparam core_state_t CORE_RST = '{lines_prev: 6'h3f, nmi_prev: 1'b1,
                                         taken_id: TAKEN_NONE, default: '0};
endpackage

// *** rtl/evt_irq_if.sv ***
// evt_irq_if: register bus and active-low request lines between the event block and the core.
// assumes both ends share aclk; no clocking block, the bench joins the two modports.
`timescale 1ns/1ps
interface evt_irq_if;
    logic        bus_sel;
    logic        bus_wr;
    logic [3:0]  bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic        bus_ack;
    logic        core_line_two_n;
    logic        core_line_three_n;
    logic        core_line_four_n;

    modport device (
        input  bus_sel, bus_wr, bus_addr, bus_wdata,
        output bus_rdata, bus_ack, core_line_two_n, core_line_three_n, core_line_four_n
    );
    modport core (
        output bus_sel, bus_wr, bus_addr, bus_wdata,
        input  bus_rdata, bus_ack, core_line_two_n, core_line_three_n, core_line_four_n
    );
endinterface

// *** rtl/event_interrupt_controller.sv ***
// event_interrupt_controller: three event groups with flag, mask and vector registers.
// assumes event inputs are one-cycle pulses synchronous to aclk and the core
// reaches the registers over the link bus, one access per bus_sel pulse.
//
// Contract
// - three groups drive core lines two, three, four
// - per-group flag and mask; mask zero blocks
// - each group has an 8-bit vector register
// - vector names highest pending unmasked event
// - group a order and ids 20h..2ah
// - group b order and ids 2bh..32h
// - group c captures 1..4, ids 33h..36h
// - event sets its flag bit
// - group requests while any flag set and unmasked; the line is released for one cycle after each vector read
// - vector read returns id, clears that flag
// - writing one clears flag, zero keeps
// - vector reads zero when nothing pending
// - 16-bit registers, unused bits zero, unwritable
// - flags set and readable while masked
// - core has six maskable lines plus nmi
// - core flags falling edge on a line
// - core takes only when flag, masks allow
// - core clears flag on take or write-one
// - global mask blocks all maskable lines
`timescale 1ns/1ps
module event_interrupt_controller
    import evt_irq_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  power_drive_protect_event,
    input  wire logic  full_compare1_event,
    input  wire logic  full_compare2_event,
    input  wire logic  full_compare3_event,
    input  wire logic  simple_compare1_event,
    input  wire logic  simple_compare2_event,
    input  wire logic  simple_compare3_event,
    input  wire logic  timer1_period_event,
    input  wire logic  timer1_compare_event,
    input  wire logic  timer1_underflow_event,
    input  wire logic  timer1_overflow_event,
    input  wire logic  timer2_period_event,
    input  wire logic  timer2_compare_event,
    input  wire logic  timer2_underflow_event,
    input  wire logic  timer2_overflow_event,
    input  wire logic  timer3_period_event,
    input  wire logic  timer3_compare_event,
    input  wire logic  timer3_underflow_event,
    input  wire logic  timer3_overflow_event,
    input  wire logic  capture1_event,
    input  wire logic  capture2_event,
    input  wire logic  capture3_event,
    input  wire logic  capture4_event,
    evt_irq_if.device  link
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // lowest set bit wins: bit 0 is the highest priority in every group
    function automatic logic [7:0] top_vector(
        input logic [15:0] p,
        input logic [7:0]  base
    );
        logic [7:0] v;
        v = VEC_NONE;
        for (int i = 15; i >= 0; i--)
        begin
            if (p[i])
            begin
                v = base + 8'(i);
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    dev_state_t       q;
    dev_state_t       d;
    logic [2:0][15:0] events;
    logic [2:0][15:0] pend;
    logic [2:0][15:0] pend_next;
    logic [2:0][15:0] clr;
    logic [2:0]       vec_rd;

    // bit order inside each group is its priority order
    assign events[0] = {5'h00,
                        timer1_overflow_event,
                        timer1_underflow_event,
                        timer1_compare_event,
                        timer1_period_event,
                        simple_compare3_event,
                        simple_compare2_event,
                        simple_compare1_event,
                        full_compare3_event,
                        full_compare2_event,
                        full_compare1_event,
                        power_drive_protect_event};
    assign events[1] = {8'h00,
                        timer3_overflow_event,
                        timer3_underflow_event,
                        timer3_compare_event,
                        timer3_period_event,
                        timer2_overflow_event,
                        timer2_underflow_event,
                        timer2_compare_event,
                        timer2_period_event};
    assign events[2] = {12'h000,
                        capture4_event,
                        capture3_event,
                        capture2_event,
                        capture1_event};

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d       = q;
        d.ack   = link.bus_sel;
        d.rdata = '0;
        clr     = '0;
        vec_rd  = '0;
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            pend[g] = q.flag[g] & q.mask[g];
            if (link.bus_sel && link.bus_addr == ADDR_W'(IDX_FLAG_A + 4'(g)))
            begin
                if (link.bus_wr)
                begin
                    clr[g] = link.bus_wdata & GRP_USED[g];
                end
                else
                begin
                    d.rdata = q.flag[g];
                end
            end
            if (link.bus_sel && link.bus_addr == ADDR_W'(IDX_MASK_A + 4'(g)))
            begin
                if (link.bus_wr)
                begin
                    d.mask[g] = link.bus_wdata & GRP_USED[g];
                end
                else
                begin
                    d.rdata = q.mask[g];
                end
            end
            // the vector register is read-only; a write there is dropped
            if (link.bus_sel && !link.bus_wr
                && link.bus_addr == ADDR_W'(IDX_VEC_A + 4'(g)))
            begin
                vec_rd[g] = 1'b1;
                d.rdata   = {8'h00, top_vector(pend[g], GRP_VEC_BASE[g])};
                clr[g]    = clr[g] | (pend[g] & (~pend[g] + 16'h0001));
            end
            // a new event in the clearing cycle survives the clear
            d.flag[g] = ((q.flag[g] & ~clr[g]) | events[g]) & GRP_USED[g];
            pend_next[g] = d.flag[g] & d.mask[g];
            // line rises for one cycle on a vector read so the next pending
            // flag gives the core a new falling edge
            d.line_n[g] = ~(|pend_next[g]) | vec_rd[g];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= DEV_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.bus_ack           = q.ack;
    assign link.bus_rdata         = q.rdata;
    assign link.core_line_two_n   = q.line_n[0];
    assign link.core_line_three_n = q.line_n[1];
    assign link.core_line_four_n  = q.line_n[2];

endmodule // event_interrupt_controller

// *** dv/evt_irq_props.sv ***
// evt_irq_props: checks on the link between the event block and the core end.
// assumes the link signals as plain inputs, one clock, sync active-low reset.
`timescale 1ns/1ps
module evt_irq_props
    import evt_irq_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        bus_sel,
    input wire logic        bus_wr,
    input wire logic [3:0]  bus_addr,
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_ack,
    input wire logic        core_line_two_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence vec_rd(logic [3:0] idx);
        bus_sel && !bus_wr && bus_addr == idx;
    endsequence
    sequence ack_val(logic [7:0] lo, logic [7:0] hi);
        bus_ack && (bus_rdata == 16'h0000
            || (bus_rdata >= {8'h00, lo} && bus_rdata <= {8'h00, hi}));
    endsequence
    ////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (bus_sel |=> bus_ack)
        else $error("no answer after select");
    a_ack_has_cause: assert property (bus_ack |-> $past(bus_sel))
        else $error("answer without select");
    a_idle_rdata_zero: assert property (!bus_ack |-> bus_rdata == 16'h0000)
        else $error("read data outside answer");
    a_write_rdata_zero: assert property (bus_sel && bus_wr |=> bus_rdata == 16'h0000)
        else $error("write answered with data");
    a_vec_range_a: assert property (vec_rd(IDX_VEC_A) |=> ack_val(8'h20, 8'h2a))
        else $error("group a vector out of range");
    a_vec_range_b: assert property (vec_rd(IDX_VEC_A + 4'h1) |=> ack_val(8'h2b, 8'h32))
        else $error("group b vector out of range");
    a_vec_range_c: assert property (vec_rd(IDX_VEC_A + 4'h2) |=> ack_val(8'h33, 8'h36))
        else $error("group c vector out of range");
    a_fresh_edge_a: assert property (vec_rd(IDX_VEC_A) |=> core_line_two_n)
        else $error("line two not released after vector read");
    a_pending_gives_id: assert property (vec_rd(IDX_VEC_A) ##0 !core_line_two_n
        |=> bus_rdata != 16'h0000) else $error("pending group read as empty");
endmodule // evt_irq_props

// *** dv/testbench.sv ***
// testbench: joins both ends over the link, drives events and the axi side.
// assumes 25 MHz aclk; only the watchdog bounds the waits.
`timescale 1ns/1ps
module testbench;
    import evt_irq_pkg::*;
    typedef struct packed {logic [1:0] grp; logic [3:0] bit_idx; logic [7:0] vec;} row_t;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic [2:0][15:0] ev = '0;
    logic             nmi_n = 1'b1;
    logic [2:0]       other_n = 3'b111;
    logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]      wdata = 32'h0, rdata, rd;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic             rready = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [2:0]       lines;
    int               error_cnt = 0;
    int               checked = 0;
    row_t             rows [0:8] = '{'{0, 0, 8'h20}, '{0, 7, 8'h27}, '{0, 10, 8'h2a},
        '{1, 0, 8'h2b}, '{1, 4, 8'h2f}, '{1, 7, 8'h32}, '{2, 0, 8'h33}, '{2, 1, 8'h34},
        '{2, 3, 8'h36}};
    evt_irq_if link ();
    assign lines = {link.core_line_four_n, link.core_line_three_n, link.core_line_two_n};
    always #20 aclk = ~aclk;
    event_interrupt_controller u_event_interrupt_controller (.aclk(aclk), .aresetn(aresetn),
        .power_drive_protect_event(ev[0][0]), .full_compare1_event(ev[0][1]),
        .full_compare2_event(ev[0][2]), .full_compare3_event(ev[0][3]),
        .simple_compare1_event(ev[0][4]), .simple_compare2_event(ev[0][5]),
        .simple_compare3_event(ev[0][6]), .timer1_period_event(ev[0][7]),
        .timer1_compare_event(ev[0][8]), .timer1_underflow_event(ev[0][9]),
        .timer1_overflow_event(ev[0][10]), .timer2_period_event(ev[1][0]),
        .timer2_compare_event(ev[1][1]), .timer2_underflow_event(ev[1][2]),
        .timer2_overflow_event(ev[1][3]), .timer3_period_event(ev[1][4]),
        .timer3_compare_event(ev[1][5]), .timer3_underflow_event(ev[1][6]),
        .timer3_overflow_event(ev[1][7]), .capture1_event(ev[2][0]),
        .capture2_event(ev[2][1]), .capture3_event(ev[2][2]), .capture4_event(ev[2][3]),
        .link(link.device));
    core_interrupt_end u_core_interrupt_end (.aclk(aclk), .aresetn(aresetn), .nmi_n(nmi_n),
        .other_lines_n(other_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link(link.core));
    evt_irq_props u_evt_irq_props (.aclk(aclk), .aresetn(aresetn), .bus_sel(link.bus_sel),
        .bus_wr(link.bus_wr), .bus_addr(link.bus_addr), .bus_rdata(link.bus_rdata),
        .bus_ack(link.bus_ack), .core_line_two_n(link.core_line_two_n));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // every task that drives a signal opens on an edge so no strobe is driven twice in one step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        @(posedge aclk);
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (aw && awready)
                awvalid <= 1'b0;
            if (w && wready)
                wvalid <= 1'b0;
            aw = aw && !awready;
            w = w && !wready;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask
    task automatic axi_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        axi_rd(a, d);
        chk(d, e);
    endtask
    // device access launched through the command register, then busy polled
    task automatic dev_rw(input logic wr, input logic [3:0] idx, input logic [15:0] wd,
                          output logic [15:0] got);
        logic [31:0] s;
        axi_wr(OFS_CMD_WDATA, {16'h0000, wd});
        axi_wr(OFS_CMD, {23'h0, wr, 4'h0, idx});
        do axi_rd(OFS_DEV_STATUS, s); while (s[0]);
        got = s[31:16];
    endtask
    task automatic dev_wr(input logic [3:0] idx, input logic [15:0] wd);
        logic [15:0] g;
        dev_rw(1'b1, idx, wd, g);
    endtask
    task automatic dev_chk(input logic [3:0] idx, input logic [15:0] e);
        logic [15:0] g;
        dev_rw(1'b0, idx, 16'h0000, g);
        chk({16'h0000, g}, {16'h0000, e});
    endtask
    task automatic pulse(input logic [1:0] g, input logic [15:0] bits);
        @(posedge aclk);
        ev[g] <= bits;
        @(posedge aclk);
        ev[g] <= 16'h0000;
        repeat (2) @(posedge aclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        #800000;
        chk(32'h0, 32'h1);
        tally_and_finish();
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({29'h0, lines}, 32'h7);
        dev_chk(IDX_MASK_A, 16'h0000);
        for (int g = 0; g < 3; g++)
        begin
            dev_wr(IDX_MASK_A + 4'(g), 16'hffff);
            dev_chk(IDX_MASK_A + 4'(g), GRP_USED[g]);
        end
        $display("test reset and masks done");
        foreach (rows[i])
        begin
            pulse(rows[i].grp, 16'h0001 << rows[i].bit_idx);
            chk({29'h0, lines}, {29'h0, ~(3'b001 << rows[i].grp)});
            dev_chk(IDX_VEC_A + {2'b00, rows[i].grp}, {8'h00, rows[i].vec});
            dev_chk(IDX_VEC_A + {2'b00, rows[i].grp}, 16'h0000);
            chk({29'h0, lines}, 32'h7);
        end
        $display("test vector table done");
        dev_wr(IDX_MASK_A + 4'h1, 16'h0000);
        pulse(2'd1, 16'h0008);
        chk({29'h0, lines}, 32'h7);
        dev_chk(IDX_FLAG_A + 4'h1, 16'h0008);
        dev_chk(IDX_VEC_A + 4'h1, 16'h0000);
        dev_wr(IDX_FLAG_A + 4'h1, 16'hfff7);
        dev_chk(IDX_FLAG_A + 4'h1, 16'h0008);
        dev_wr(IDX_FLAG_A + 4'h1, 16'h0008);
        dev_chk(IDX_FLAG_A + 4'h1, 16'h0000);
        dev_chk(4'hf, 16'h0000);
        $display("test masked flags done");
        pulse(2'd0, 16'h0108);
        dev_chk(IDX_VEC_A, 16'h0023);
        chk({29'h0, lines}, 32'h6);
        dev_chk(IDX_VEC_A, 16'h0028);
        dev_chk(IDX_FLAG_A, 16'h0000);
        $display("test priority done");
        axi_wr(OFS_CORE_FLAG, 32'h0000_003f);
        axi_wr(OFS_CORE_MASK, 32'h0000_0002);
        axi_chk(OFS_TAKEN, 32'h0);
        pulse(2'd0, 16'h0001);
        axi_chk(OFS_TAKEN, 32'h2);
        axi_chk(OFS_GLOBAL, 32'h1);
        dev_chk(IDX_VEC_A, 16'h0020);
        pulse(2'd0, 16'h0002);
        axi_rd(OFS_CORE_FLAG, rd);
        chk({31'h0, rd[1]}, 32'h1);
        nmi_n <= 1'b0;
        repeat (3) @(posedge aclk);
        nmi_n <= 1'b1;
        axi_chk(OFS_TAKEN, 32'h7);
        axi_wr(OFS_GLOBAL, 32'h0);
        axi_chk(OFS_TAKEN, 32'h2);
        axi_rd(OFS_CORE_FLAG, rd);
        chk({31'h0, rd[1]}, 32'h0);
        axi_chk(8'hfc, 32'h0);
        // lines one and six fall together while taking is blocked; line one must go first
        other_n <= 3'b010;
        axi_wr(OFS_CORE_MASK, 32'h0000_0021);
        axi_wr(OFS_GLOBAL, 32'h0);
        axi_chk(OFS_TAKEN, 32'h1);
        axi_wr(OFS_GLOBAL, 32'h0);
        axi_chk(OFS_TAKEN, 32'h6);
        other_n <= 3'b111;
        $display("test core taking done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({29'h0, lines}, 32'h7);
        dev_chk(IDX_FLAG_A, 16'h0000);
        dev_chk(IDX_MASK_A + 4'h2, 16'h0000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // testbench
